// ===== rtl/slot_pkg.sv
// shared constants and types for the slot host interface
package slot_pkg;
	// slot offsets
	localparam logic [17:0] OFS_CMD = 18'h3FFEE;
	localparam logic [17:0] OFS_ID_A = 18'h3FFF9;
	localparam logic [17:0] OFS_ID_B = 18'h3FFFA;
	localparam logic [17:0] OFS_CHK_A = 18'h3FFFC;
	localparam logic [17:0] OFS_CHK_B = 18'h3FFFE;
	localparam int OFS_UPPER_BIT = 17;
	// command bit positions
	localparam int CMD_RUN = 0;
	localparam int CMD_BRQ_N = 1;
	localparam int CMD_CLR = 2;
	localparam int CMD_MODE = 3;
	localparam int CMD_SEL_LO = 4;
	// status bit positions
	localparam int STS_GRANT_N = 5;
	localparam int STS_PEND = 7;
	// reset values
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [1:0] PAGE_RESET = 2'h0;
	// local processor start address after reset release
	localparam logic [19:0] BOOT_VECTOR = 20'h1FFF0;
	// host-end own register indices (word index, address bit 18 set)
	localparam logic [1:0] AV_RUN = 2'h0;
	localparam logic [1:0] AV_ACQ = 2'h1;
	localparam logic [1:0] AV_INT = 2'h2;
	localparam logic [1:0] AV_CLR = 2'h3;
	localparam int AV_OWN_BIT = 18;
	// status poll limit of the host acquire sequence
	localparam logic [7:0] POLL_MAX = 8'hFF;
	// arbitration states, gray along idle-req-wait-own-release
	typedef enum logic [2:0] {
		ARB_IDLE = 3'b000,
		ARB_REQ = 3'b001,
		ARB_WAIT = 3'b011,
		ARB_OWN = 3'b010,
		ARB_REL = 3'b110
	} arb_t;
	// host sequencer states
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_ISSUE = 2'b01,
		HS_DONE = 2'b11
	} hseq_t;
	// host sequence kinds
	typedef enum logic [2:0] {
		K_PASS = 3'h0,
		K_RUN = 3'h1,
		K_ACQ = 3'h2,
		K_REL = 3'h3,
		K_INT = 3'h4,
		K_CLR = 3'h5
	} kind_t;
endpackage

// ===== rtl/slot_link_if.sv
// slot bus between host controller and coprocessor board
`timescale 1ns/10ps
interface slot_link_if (
	input wire logic clk // host peripheral clock
);
	logic [20:0] slot_addr; // [20:18] slot number, [17:0] offset
	logic io_cycle; // host i/o cycle in progress
	logic rd; // read strobe, held until ack
	logic wr; // write strobe, held until ack
	logic [7:0] wdata; // write data
	logic host_refresh_grant; // host refresh grant
	logic ack; // one-cycle transfer acknowledge
	logic [7:0] rdata; // read data, valid with ack
	logic host_interrupt_request_n; // interrupt line on host level one
	modport host_end (
		input clk, ack, rdata, host_interrupt_request_n,
		output slot_addr, io_cycle, rd, wr, wdata, host_refresh_grant
	);
	modport board_end (
		input clk, slot_addr, io_cycle, rd, wr, wdata, host_refresh_grant,
		output ack, rdata, host_interrupt_request_n
	);
endinterface

// ===== rtl/board_end.sv
// coprocessor board end of the slot interface
//
// Overview of operation
// - selected 128K page appears in lower slot half
// - host owns RAM in reset, processor after
// - host writes page bits before memory request
// - state machine turns request into pulse handshake
// - grant pulse raises bus acknowledge, swaps drivers
// - host waits for acknowledge before RAM access
// - host refresh grant drives refresh while owned
// - request withdrawn, release sequence returns RAM
// - host interrupt uses host level one
// - fixed read-only identification bytes at top
// - one register: commands written, status read
// - command bit 0 runs or resets processor
// - processor starts at fixed boot address
// - command bit 1 low requests the bus
// - bit 2 one then zero clears interrupt
// - bit 3 low interrupts processor, bits 4-7
// - bit 3 high selects page from bits 4-5
// - status bits 0-4 give request type
// - status bit 5 low when bus granted
// - status bit 7 pending, bit 6 reserved
// - status port write with bit 7 interrupts host
// - own access decoded from slot number, registered
// - upper half registers, lower half RAM
`timescale 1ns/10ps
module board_end #(
	parameter logic [2:0] SLOT_ID = 3'h0, // hardwired slot number
	parameter logic [7:0] ID_A = 8'h11, // arbitrary value
	parameter logic [7:0] ID_B = 8'h22, // arbitrary value
	parameter logic [7:0] CHK_A = 8'h33, // arbitrary value
	parameter logic [7:0] CHK_B = 8'h44 // arbitrary value
) (
	input wire logic clk, // host peripheral clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic ce, // clock enable
	slot_link_if.board_end link, // slot bus
	output logic proc_reset, // local processor held in reset
	output logic [19:0] boot_vector, // processor start address
	output logic proc_rq, // request/release pulse to processor
	input wire logic proc_gt, // grant pulse from processor (pin)
	output logic local_bus_acknowledge_n, // host owns local bus, low
	output logic [18:0] ram_addr, // local RAM address
	output logic [7:0] ram_wdata, // local RAM write data
	output logic ram_we, // local RAM write pulse
	output logic ram_re, // local RAM read pulse
	input wire logic [7:0] ram_rdata, // RAM data, sampled in the ram_re cycle
	output logic ram_refresh, // refresh cycle request
	output logic [3:0] local_irq, // one-cycle interrupt pulses
	input wire logic local_status_write_port, // processor status write
	input wire logic [7:0] local_status_data // processor status data
);
	////////////////////////////////////////////////////////////////////
	// identification lookup
	function automatic logic [7:0] id_byte(input logic [17:0] ofs);
		logic [7:0] v;
		v = 8'h00;
		if (ofs == slot_pkg::OFS_ID_A) begin
			v = ID_A;
		end else if (ofs == slot_pkg::OFS_ID_B) begin
			v = ID_B;
		end else if (ofs == slot_pkg::OFS_CHK_A) begin
			v = CHK_A;
		end else if (ofs == slot_pkg::OFS_CHK_B) begin
			v = CHK_B;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////
	// state
	logic [7:0] cmd_q, cmd_d;
	logic [1:0] page_q, page_d;
	logic pend_q, pend_d;
	logic [4:0] type_q, type_d;
	slot_pkg::arb_t arb_q, arb_d;
	logic io_q, io_d;
	logic done_q, done_d;
	logic wait_q, wait_d;
	logic ack_q, ack_d;
	logic [7:0] rdata_q, rdata_d;
	logic [18:0] raddr_q, raddr_d;
	logic [7:0] rwd_q, rwd_d;
	logic we_q, we_d;
	logic re_q, re_d;
	logic refr_q, refr_d;
	logic [3:0] irq_q, irq_d;
	logic rq_q, rq_d;
	logic gt_s1_q, gt_s2_q, gt_s3_q;
	logic gt_ev, run, host_owns, sel, upper;

	// grant pin synchroniser and edge detect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gt_s1_q <= 1'b0;
			gt_s2_q <= 1'b0;
			gt_s3_q <= 1'b0;
		end else if (ce) begin
			gt_s1_q <= proc_gt;
			gt_s2_q <= gt_s1_q;
			gt_s3_q <= gt_s2_q;
		end
	end
	assign gt_ev = gt_s2_q & ~gt_s3_q;

	// ownership and access decode
	assign run = cmd_q[slot_pkg::CMD_RUN];
	assign host_owns = ~run | (arb_q == slot_pkg::ARB_OWN);
	assign sel = link.io_cycle & (link.slot_addr[20:18] == SLOT_ID) & (link.rd | link.wr);
	assign upper = link.slot_addr[slot_pkg::OFS_UPPER_BIT];

	////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		cmd_d = cmd_q;
		page_d = page_q;
		pend_d = pend_q;
		type_d = type_q;
		arb_d = arb_q;
		io_d = sel;
		done_d = done_q & io_q;
		wait_d = 1'b0;
		ack_d = 1'b0;
		rdata_d = rdata_q;
		raddr_d = raddr_q;
		rwd_d = rwd_q;
		we_d = 1'b0;
		re_d = 1'b0;
		irq_d = 4'h0;
		rq_d = 1'b0;
		refr_d = host_owns & link.host_refresh_grant;
		// arbitration handshake
		if (!run) begin
			arb_d = slot_pkg::ARB_IDLE;
		end else begin
			case (arb_q)
				slot_pkg::ARB_IDLE: begin
					if (!cmd_q[slot_pkg::CMD_BRQ_N]) begin
						arb_d = slot_pkg::ARB_REQ;
						rq_d = 1'b1;
					end
				end
				slot_pkg::ARB_REQ: begin
					arb_d = slot_pkg::ARB_WAIT;
				end
				slot_pkg::ARB_WAIT: begin
					if (gt_ev) begin
						arb_d = slot_pkg::ARB_OWN;
					end
				end
				slot_pkg::ARB_OWN: begin
					if (cmd_q[slot_pkg::CMD_BRQ_N]) begin
						arb_d = slot_pkg::ARB_REL;
						rq_d = 1'b1;
					end
				end
				default: begin
					arb_d = slot_pkg::ARB_IDLE;
				end
			endcase
		end
		// pending RAM read completes
		if (wait_q) begin
			rdata_d = ram_rdata;
			ack_d = 1'b1;
			done_d = 1'b1;
		end else if (io_q && !done_q) begin
			ack_d = 1'b1;
			done_d = 1'b1;
			if (!upper) begin
				raddr_d = {page_q, link.slot_addr[16:0]};
				rwd_d = link.wdata;
				if (host_owns) begin
					we_d = link.wr;
					re_d = link.rd;
					wait_d = link.rd;
					ack_d = ~link.rd;
					done_d = ~link.rd;
				end else begin
					rdata_d = 8'h00;
				end
			end else if (link.slot_addr[17:0] == slot_pkg::OFS_CMD) begin
				if (link.wr) begin
					cmd_d = link.wdata;
					if (link.wdata[slot_pkg::CMD_MODE]) begin
						page_d = link.wdata[slot_pkg::CMD_SEL_LO +: 2];
					end else begin
						irq_d = link.wdata[slot_pkg::CMD_SEL_LO +: 4];
					end
					if (cmd_q[slot_pkg::CMD_CLR] && !link.wdata[slot_pkg::CMD_CLR]) begin
						pend_d = 1'b0;
					end
				end else begin
					rdata_d = {pend_q, 1'b0, ~host_owns, type_q};
				end
			end else begin
				rdata_d = link.rd ? id_byte(link.slot_addr[17:0]) : rdata_q;
			end
		end
		// processor status write, set wins over clear
		if (local_status_write_port) begin
			type_d = local_status_data[4:0];
			if (local_status_data[7]) begin
				pend_d = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_q <= slot_pkg::CMD_RESET;
			page_q <= slot_pkg::PAGE_RESET;
			pend_q <= 1'b0;
			type_q <= 5'h00;
			arb_q <= slot_pkg::ARB_IDLE;
			io_q <= 1'b0;
			done_q <= 1'b0;
			wait_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
			raddr_q <= 19'h00000;
			rwd_q <= 8'h00;
			we_q <= 1'b0;
			re_q <= 1'b0;
			refr_q <= 1'b0;
			irq_q <= 4'h0;
			rq_q <= 1'b0;
		end else if (ce) begin
			cmd_q <= cmd_d;
			page_q <= page_d;
			pend_q <= pend_d;
			type_q <= type_d;
			arb_q <= arb_d;
			io_q <= io_d;
			done_q <= done_d;
			wait_q <= wait_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			raddr_q <= raddr_d;
			rwd_q <= rwd_d;
			we_q <= we_d;
			re_q <= re_d;
			refr_q <= refr_d;
			irq_q <= irq_d;
			rq_q <= rq_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	assign link.ack = ack_q;
	assign link.rdata = rdata_q;
	assign link.host_interrupt_request_n = ~pend_q;
	assign proc_reset = ~run;
	assign boot_vector = slot_pkg::BOOT_VECTOR;
	assign proc_rq = rq_q;
	assign local_bus_acknowledge_n = ~host_owns;
	assign ram_addr = raddr_q;
	assign ram_wdata = rwd_q;
	assign ram_we = we_q;
	assign ram_re = re_q;
	assign ram_refresh = refr_q;
	assign local_irq = irq_q;
endmodule

// ===== rtl/host_end.sv
// host controller end of the slot interface, Avalon-MM slave to software
`timescale 1ns/10ps
module host_end #(
	parameter logic [2:0] SLOT_ID = 3'h0 // slot the board sits in
) (
	input wire logic clk, // host peripheral clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic ce, // clock enable
	slot_link_if.host_end link, // slot bus
	input wire logic refresh_grant_in, // host system refresh grant
	input wire logic [18:0] avs_address, // word address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic host_irq // board interrupt on level one, high
);
	////////////////////////////////////////////////////////////////////
	// command word built from the driver image
	function automatic logic [7:0] cmd_word(input slot_pkg::kind_t k, input logic [1:0] step,
		input logic run, input logic [1:0] pg, input logic [1:0] lvl);
		logic [7:0] w;
		w = {2'b00, pg, 1'b1, 1'b0, 1'b1, run};
		if (k == slot_pkg::K_ACQ && step != 2'd0) begin
			w[slot_pkg::CMD_BRQ_N] = 1'b0;
		end else if (k == slot_pkg::K_INT) begin
			w[7:4] = 4'h1 << lvl;
			w[slot_pkg::CMD_MODE] = 1'b0;
		end else if (k == slot_pkg::K_CLR && step == 2'd0) begin
			w[slot_pkg::CMD_CLR] = 1'b1;
		end
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////
	// state
	slot_pkg::hseq_t st_q, st_d;
	slot_pkg::kind_t kind_q, kind_d;
	logic [1:0] step_q, step_d;
	logic [7:0] poll_q, poll_d;
	logic run_q, run_d;
	logic [1:0] page_q, page_d;
	logic [1:0] lvl_q, lvl_d;
	logic granted_q, granted_d;
	logic [17:0] addr_q, addr_d;
	logic rd_q, rd_d;
	logic wr_q, wr_d;
	logic nrd_q, nrd_d;
	logic nwr_q, nwr_d;
	logic [7:0] wdata_q, wdata_d;
	logic [31:0] rdat_q, rdat_d;
	logic own;

	assign own = avs_address[slot_pkg::AV_OWN_BIT];

	// sequencer next state
	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		step_d = step_q;
		poll_d = poll_q;
		run_d = run_q;
		page_d = page_q;
		lvl_d = lvl_q;
		granted_d = granted_q;
		addr_d = addr_q;
		rd_d = rd_q;
		wr_d = wr_q;
		nrd_d = nrd_q;
		nwr_d = nwr_q;
		wdata_d = wdata_q;
		rdat_d = rdat_q;
		case (st_q)
			slot_pkg::HS_IDLE: begin
				if (avs_read || avs_write) begin
					st_d = slot_pkg::HS_ISSUE;
					step_d = 2'd0;
					poll_d = 8'h00;
					rdat_d = 32'h00000000;
					addr_d = slot_pkg::OFS_CMD;
					rd_d = 1'b0;
					wr_d = 1'b1;
					if (!own) begin
						kind_d = slot_pkg::K_PASS;
						addr_d = avs_address[17:0];
						rd_d = avs_read;
						wr_d = avs_write;
						wdata_d = avs_writedata[7:0];
						// board in reset leaves the RAM to the host
						if (!avs_address[slot_pkg::OFS_UPPER_BIT] && !(granted_q || !run_q)) begin
							st_d = slot_pkg::HS_DONE;
							rd_d = 1'b0;
							wr_d = 1'b0;
						end
					end else if (avs_read) begin
						st_d = slot_pkg::HS_DONE;
						wr_d = 1'b0;
						if (avs_address[1:0] == slot_pkg::AV_RUN) begin
							rdat_d = {31'h00000000, run_q};
						end else if (avs_address[1:0] == slot_pkg::AV_ACQ) begin
							rdat_d = {31'h00000000, granted_q | ~run_q};
						end
					end else if (avs_address[1:0] == slot_pkg::AV_RUN) begin
						kind_d = slot_pkg::K_RUN;
						run_d = avs_writedata[0];
						granted_d = 1'b0;
						wdata_d = cmd_word(slot_pkg::K_RUN, 2'd0, avs_writedata[0], page_q, lvl_q);
					end else if (avs_address[1:0] == slot_pkg::AV_ACQ && avs_writedata[0]) begin
						kind_d = slot_pkg::K_ACQ;
						page_d = avs_writedata[2:1];
						// page written first, request afterwards
						wdata_d = cmd_word(slot_pkg::K_ACQ, 2'd0, run_q, avs_writedata[2:1], lvl_q);
					end else if (avs_address[1:0] == slot_pkg::AV_ACQ) begin
						kind_d = slot_pkg::K_REL;
						granted_d = 1'b0;
						wdata_d = cmd_word(slot_pkg::K_REL, 2'd0, run_q, page_q, lvl_q);
					end else if (avs_address[1:0] == slot_pkg::AV_INT) begin
						kind_d = slot_pkg::K_INT;
						lvl_d = avs_writedata[1:0];
						wdata_d = cmd_word(slot_pkg::K_INT, 2'd0, run_q, page_q, avs_writedata[1:0]);
					end else begin
						kind_d = slot_pkg::K_CLR;
						wdata_d = cmd_word(slot_pkg::K_CLR, 2'd0, run_q, page_q, lvl_q);
					end
				end
			end
			slot_pkg::HS_ISSUE: begin
				if (!rd_q && !wr_q) begin
					// one idle strobe cycle lets the board rearm for the next op
					rd_d = nrd_q;
					wr_d = nwr_q;
				end else if (link.ack) begin
					rd_d = 1'b0;
					wr_d = 1'b0;
					nrd_d = 1'b0;
					nwr_d = 1'b0;
					st_d = slot_pkg::HS_DONE;
					if (kind_q == slot_pkg::K_PASS) begin
						rdat_d = {24'h000000, link.rdata};
					end else if (kind_q == slot_pkg::K_CLR && step_q == 2'd0) begin
						st_d = slot_pkg::HS_ISSUE;
						step_d = 2'd1;
						nwr_d = 1'b1;
						wdata_d = cmd_word(slot_pkg::K_CLR, 2'd1, run_q, page_q, lvl_q);
					end else if (kind_q == slot_pkg::K_ACQ && step_q == 2'd0) begin
						st_d = slot_pkg::HS_ISSUE;
						step_d = 2'd1;
						nwr_d = 1'b1;
						wdata_d = cmd_word(slot_pkg::K_ACQ, 2'd1, run_q, page_q, lvl_q);
					end else if (kind_q == slot_pkg::K_ACQ) begin
						// poll status until the grant bit goes low
						step_d = 2'd2;
						if (step_q == 2'd2 && !link.rdata[slot_pkg::STS_GRANT_N]) begin
							granted_d = 1'b1;
						end else if (poll_q != slot_pkg::POLL_MAX) begin
							st_d = slot_pkg::HS_ISSUE;
							nrd_d = 1'b1;
							poll_d = poll_q + 8'h01;
						end
					end
				end
			end
			default: begin
				st_d = slot_pkg::HS_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= slot_pkg::HS_IDLE;
			kind_q <= slot_pkg::K_PASS;
			step_q <= 2'd0;
			poll_q <= 8'h00;
			run_q <= 1'b0;
			page_q <= slot_pkg::PAGE_RESET;
			lvl_q <= 2'h0;
			granted_q <= 1'b0;
			addr_q <= 18'h00000;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			nrd_q <= 1'b0;
			nwr_q <= 1'b0;
			wdata_q <= 8'h00;
			rdat_q <= 32'h00000000;
		end else if (ce) begin
			st_q <= st_d;
			kind_q <= kind_d;
			step_q <= step_d;
			poll_q <= poll_d;
			run_q <= run_d;
			page_q <= page_d;
			lvl_q <= lvl_d;
			granted_q <= granted_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			nrd_q <= nrd_d;
			nwr_q <= nwr_d;
			wdata_q <= wdata_d;
			rdat_q <= rdat_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	assign link.slot_addr = {SLOT_ID, addr_q};
	assign link.io_cycle = rd_q | wr_q;
	assign link.rd = rd_q;
	assign link.wr = wr_q;
	assign link.wdata = wdata_q;
	assign link.host_refresh_grant = refresh_grant_in;
	assign avs_readdata = rdat_q;
	assign avs_waitrequest = (st_q != slot_pkg::HS_DONE);
	assign host_irq = ~link.host_interrupt_request_n;
endmodule

// ===== sim/slot_monitor.sv
// checker of the slot bus between host end and board end
`timescale 1ns/10ps
module slot_monitor #(
	parameter logic [2:0] SLOT_ID = 3'h0, // slot of the board
	parameter logic [7:0] ID_A = 8'h11 // arbitrary value
) (
	input wire logic clk, // bus clock
	input wire logic sys_rst, // synchronous reset
	input wire logic [20:0] slot_addr, // slot and offset
	input wire logic io_cycle, // i/o cycle
	input wire logic rd, // read strobe
	input wire logic wr, // write strobe
	input wire logic [7:0] wdata, // write data
	input wire logic ack, // transfer acknowledge
	input wire logic [7:0] rdata, // read data
	input wire logic host_interrupt_request_n // board interrupt, low
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	// one transfer: strobe rises, answer follows
	sequence s_start;
		$rose(rd || wr);
	endsequence
	sequence s_answer;
		##[2:3] ack;
	endsequence
	a_ack_timely: assert property (s_start |-> s_answer)
		else $error("slot transfer not answered in time");
	a_ack_single: assert property (ack |=> !ack)
		else $error("acknowledge longer than one cycle");
	a_strobe_held: assert property ((rd || wr) && !ack |=> (rd || wr) && $stable(slot_addr))
		else $error("strobe or address changed before acknowledge");
	a_wdata_held: assert property (wr && !ack |=> $stable(wdata))
		else $error("write data changed before acknowledge");
	a_strobe_drop: assert property (ack |=> !(rd || wr))
		else $error("strobe still high after acknowledge");
	a_rw_apart: assert property (!(rd && wr))
		else $error("read and write together");
	a_io_level: assert property (io_cycle == (rd || wr))
		else $error("i/o cycle differs from strobes");
	a_ack_slot: assert property (ack |-> (rd || wr) && slot_addr[20:18] == SLOT_ID)
		else $error("acknowledge outside own slot");
	a_ident_value: assert property (rd && ack && slot_addr[17:0] == slot_pkg::OFS_ID_A
		|-> rdata == ID_A)
		else $error("identification byte wrong");
	a_pend_status: assert property (rd && ack && slot_addr[17:0] == slot_pkg::OFS_CMD
		|-> rdata[7] == !host_interrupt_request_n)
		else $error("pending bit differs from interrupt line");
endmodule

// ===== sim/test_slot_host_interface.sv
// self-checking bench of host end and board end joined by the slot bus
`timescale 1ns/10ps
module test_slot_host_interface;
	localparam logic [2:0] SLOT = 3'h5;
	localparam logic [17:0] IDO [4] = '{slot_pkg::OFS_ID_A, slot_pkg::OFS_ID_B,
		slot_pkg::OFS_CHK_A, slot_pkg::OFS_CHK_B};
	localparam logic [7:0] IDV [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic refresh_grant_in = 1'b0;
	logic [18:0] avs_address = 19'h00000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, host_irq, proc_reset, proc_rq, local_bus_acknowledge_n;
	logic ram_we, ram_re, ram_refresh, rf_q;
	logic proc_gt = 1'b0;
	logic sts_wr = 1'b0;
	logic want_own = 1'b0;
	logic [19:0] boot_vector;
	logic [18:0] ram_addr, we_addr, re_addr;
	logic [7:0] ram_wdata, we_data, q;
	logic [7:0] ram_rdata = 8'h00;
	logic [7:0] sts_data = 8'h00;
	logic [4:0] ty;
	logic [3:0] local_irq;
	logic [3:0] irq_seen = 4'h0;
	logic [3:0] gt_cnt = 4'h0;
	int mismatches = 0;
	int cmp_count = 0;
	int rq_cnt = 0;

	always #25 clk = ~clk;

	slot_link_if link (.clk(clk));
	host_end #(.SLOT_ID(SLOT)) i_host_end (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
		.link(link), .refresh_grant_in(refresh_grant_in), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_irq(host_irq));
	board_end #(.SLOT_ID(SLOT)) i_board_end (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
		.link(link), .proc_reset(proc_reset), .boot_vector(boot_vector), .proc_rq(proc_rq),
		.proc_gt(proc_gt), .local_bus_acknowledge_n(local_bus_acknowledge_n),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re),
		.ram_rdata(ram_rdata), .ram_refresh(ram_refresh), .local_irq(local_irq),
		.local_status_write_port(sts_wr), .local_status_data(sts_data));
	slot_monitor #(.SLOT_ID(SLOT), .ID_A(8'h11)) i_slot_monitor (.clk(clk),
		.sys_rst(sys_rst), .slot_addr(link.slot_addr), .io_cycle(link.io_cycle),
		.rd(link.rd), .wr(link.wr), .wdata(link.wdata), .ack(link.ack),
		.rdata(link.rdata), .host_interrupt_request_n(link.host_interrupt_request_n));

	////////////////////////////////////////////////////////////////
	// processor grant model, refresh stimulus and output capture
	always @(posedge clk) begin
		if (proc_rq === 1'b1 && want_own)
			gt_cnt <= 4'h3 + 4'($urandom % 4);
		else if (gt_cnt != 4'h0)
			gt_cnt <= gt_cnt - 4'h1;
		proc_gt <= (gt_cnt == 4'h2 || gt_cnt == 4'h1);
		refresh_grant_in <= 1'($urandom);
		rf_q <= refresh_grant_in;
		if (proc_rq === 1'b1)
			rq_cnt <= rq_cnt + 1;
		if (ram_we === 1'b1) begin
			we_addr <= ram_addr;
			we_data <= ram_wdata;
		end
		if (ram_re === 1'b1)
			re_addr <= ram_addr;
		if (|local_irq)
			irq_seen <= local_irq;
	end

	////////////////////////////////////////////////////////////////
	// expectations, comparison and bus tasks
	function automatic logic [7:0] sts_exp(input logic p, input logic o, input logic [4:0] t);
		return {p, 1'b0, ~o, t};
	endfunction

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task av(input logic w, input logic [18:0] a, input logic [7:0] dv, output logic [7:0] rv);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, dv};
		avs_read <= !w;
		avs_write <= w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 3000);
		rv = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 3000)
			mismatches++;
	endtask

	task own(input logic w, input logic [1:0] idx, input logic [7:0] dv);
		av(w, {1'b1, 16'h0000, idx}, dv, q);
	endtask

	task sts(input logic p, input logic o, input logic [4:0] t);
		av(1'b0, {1'b0, slot_pkg::OFS_CMD}, 8'h00, q);
		chk("status", q & 8'hBF, sts_exp(p, o, t));
	endtask

	task ram_op(input logic [1:0] pg);
		logic [16:0] a;
		logic [7:0] v;
		a = 17'($urandom);
		v = 8'($urandom);
		av(1'b1, {2'b00, a}, v, q);
		chk("ram_addr", we_addr, {pg, a});
		chk("ram_wdata", we_data, v);
		v = 8'($urandom);
		ram_rdata <= v;
		av(1'b0, {2'b00, a}, 8'h00, q);
		chk("ram_read", q, v);
		chk("ram_raddr", re_addr, {pg, a});
	endtask

	task rf_chk(input logic o);
		repeat (6) begin
			@(negedge clk);
			chk("ram_refresh", ram_refresh, rf_q & o);
		end
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#2000000;
		mismatches++;
		finish_test;
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(77823));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk("proc_reset", proc_reset, 1'b1);
		chk("bus_ack_n", local_bus_acknowledge_n, 1'b0);
		chk("boot_vector", boot_vector, slot_pkg::BOOT_VECTOR);
		chk("host_irq", host_irq, 1'b0);
		av(1'b1, {1'b0, slot_pkg::OFS_ID_A}, 8'hFF, q);
		for (int i = 0; i < 4; i++) begin
			av(1'b0, {1'b0, IDO[i]}, 8'h00, q);
			chk("ident", q, IDV[i]);
		end
		sts(1'b0, 1'b1, 5'h00);
		ram_op(2'h0);
		own(1'b1, slot_pkg::AV_RUN, 8'h01);
		chk("proc_reset", proc_reset, 1'b0);
		chk("bus_ack_n", local_bus_acknowledge_n, 1'b1);
		sts(1'b0, 1'b0, 5'h00);
		ram_rdata <= 8'hA5;
		av(1'b0, 19'h00100, 8'h00, q);
		chk("refused", q, 8'h00);
		rf_chk(1'b0);
		for (int p = 0; p < 4; p++) begin
			want_own = 1'b1;
			own(1'b1, slot_pkg::AV_ACQ, {5'h00, 2'(p), 1'b1});
			own(1'b0, slot_pkg::AV_ACQ, 8'h00);
			chk("granted", q, 8'h01);
			chk("bus_ack_n", local_bus_acknowledge_n, 1'b0);
			sts(1'b0, 1'b1, 5'h00);
			ram_op(2'(p));
			rf_chk(1'b1);
			want_own = 1'b0;
			own(1'b1, slot_pkg::AV_ACQ, 8'h00);
			repeat (4) @(posedge clk);
			@(negedge clk);
			chk("bus_ack_n", local_bus_acknowledge_n, 1'b1);
		end
		chk("rq_pulses", rq_cnt, 8);
		chk("no_irq", irq_seen, 4'h0);
		for (int l = 0; l < 4; l++) begin
			own(1'b1, slot_pkg::AV_INT, 8'(l));
			chk("local_irq", irq_seen, 4'h1 << l);
		end
		ty = 5'($urandom);
		@(posedge clk);
		sts_wr <= 1'b1;
		sts_data <= {3'h4, ty};
		@(posedge clk);
		sts_wr <= 1'b0;
		repeat (3) @(negedge clk);
		chk("host_irq", host_irq, 1'b1);
		sts(1'b1, 1'b0, ty);
		own(1'b1, slot_pkg::AV_CLR, 8'h00);
		@(negedge clk);
		chk("host_irq", host_irq, 1'b0);
		sts(1'b0, 1'b0, ty);
		own(1'b1, slot_pkg::AV_RUN, 8'h00);
		@(negedge clk);
		chk("proc_reset", proc_reset, 1'b1);
		chk("bus_ack_n", local_bus_acknowledge_n, 1'b0);
		finish_test;
	end
endmodule
